// ==== logic/uc_fault_pkg.sv ====
package uc_fault_pkg;
	// ----------------------------------------------------------------
	// command codes and field layout
	// ----------------------------------------------------------------
	localparam logic [7:0] UC_POLICY_CODE = 8'hE6;
	localparam logic [7:0] UC_POLICY_RESET = 8'h00;
	localparam int RESP_HI = 7;
	localparam int RESP_LO = 6;
	localparam int RETRY_HI = 5;
	localparam int RETRY_LO = 3;
	localparam int UNITS_HI = 2;
	localparam int UNITS_LO = 0;

	// ----------------------------------------------------------------
	// response and retry encodings
	// ----------------------------------------------------------------
	localparam logic [1:0] RESP_IGNORE = 2'h0;
	localparam logic [1:0] RESP_DELAY = 2'h1;
	localparam logic [1:0] RESP_DISABLE_RETRY = 2'h2;
	localparam logic [1:0] RESP_HOLD_OFF = 2'h3;
	localparam logic [2:0] RETRY_NONE = 3'h0;
	localparam logic [2:0] RETRY_FOREVER = 3'h7;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_PS = 20_000;
	localparam longint DELAY_UNIT_PS = 64'd10_000_000_000;   // 10 ms
	localparam longint RETRY_UNIT_PS = 64'd8_200_000_000;    // 8.2 ms
	localparam int DELAY_UNIT_CYCLES = int'(DELAY_UNIT_PS / CLK_PERIOD_PS);
	localparam int RETRY_UNIT_CYCLES = int'(RETRY_UNIT_PS / CLK_PERIOD_PS);

	typedef enum logic [2:0] {
		ST_OFF,
		ST_RUN,
		ST_DELAY,
		ST_OFF_WAIT,
		ST_RESTART,
		ST_LATCHED,
		ST_HOLD_OFF
	} seq_state_t;
endpackage

// ==== logic/unit_timer_if.sv ====
`timescale 1ns/1ns
interface unit_timer_if;
	logic start;      // one-cycle pulse, loads a new interval
	logic cancel;     // one-cycle pulse, or held while stopped; abandons the interval
	logic use_retry;  // 1: restart unit, 0: delay unit
	logic [2:0] units;
	logic done;       // one-cycle pulse when the interval ends

	modport ctrl (output start, output cancel, output use_retry, output units, input done);
	modport timer (input start, input cancel, input use_retry, input units, output done);
endinterface

// ==== logic/unit_timer.sv ====
`timescale 1ns/1ns
module unit_timer #(
	parameter int DELAY_CYCLES = uc_fault_pkg::DELAY_UNIT_CYCLES,
	parameter int RETRY_CYCLES = uc_fault_pkg::RETRY_UNIT_CYCLES
) (
	input wire logic clk_in,
	input wire logic srst_in,
	unit_timer_if.timer tmr
);
	logic running_reg;
	logic [31:0] rem_reg;
	logic [31:0] span;

	// interval length in clocks; the unit depends on what the interval is for
	assign span = 32'(tmr.units) * (tmr.use_retry ? 32'(RETRY_CYCLES) : 32'(DELAY_CYCLES));

	// ----------------------------------------------------------------
	// interval counter
	// ----------------------------------------------------------------
	// done is raised on the last clock so the sequencer acts exactly span clocks
	// after the start; zero units still takes one clock, the shortest possible
	always_ff @(posedge clk_in) begin
		tmr.done <= 1'b0;
		if (srst_in || tmr.cancel) begin
			running_reg <= 1'b0;
			rem_reg <= 32'h0000_0000;
		end else if (tmr.start) begin
			if (span <= 32'h0000_0001) begin
				running_reg <= 1'b0;
				tmr.done <= 1'b1;
			end else begin
				running_reg <= 1'b1;
			end
			rem_reg <= span - 32'h0000_0001;
		end else if (running_reg) begin
			rem_reg <= rem_reg - 32'h0000_0001;
			if (rem_reg == 32'h0000_0001) begin
				running_reg <= 1'b0;
				tmr.done <= 1'b1;
			end
		end
	end
endmodule

// ==== logic/uc_fault_response.sv ====
// Behaviour
// - byte register at command 0xE6 holds the policy, byte read and write
// - any fault, any response code: alert pulled low, status bit set
// - same encoding as voltage faults; sets only the undercurrent status bit
// - code 00: output keeps running, only reporting happens
// - code 01: run for delay units, then retry handling if fault remains
// - code 10: disable at once, then restart per retry count
// - code 11: output off while fault lasts, back on when it goes
// - retry 000: no restart, output stays off until fault cleared
// - retry 1..6 gives that many attempts, then latched off until cleared
// - attempts start a delay-field count of restart units apart
// - delay field counts 10 ms units for the keep-running delay
// - delay field counts 8.2 ms units between restart attempts
// - retry 111 retries forever until disabled or another fault
`timescale 1ns/1ns
module uc_fault_response #(
	parameter int DELAY_UNIT_CYCLES = uc_fault_pkg::DELAY_UNIT_CYCLES,
	parameter int RETRY_UNIT_CYCLES = uc_fault_pkg::RETRY_UNIT_CYCLES
) (
	input wire logic CLK_IN,
	input wire logic SRST_IN,
	input wire logic CMD_VALID_IN,
	input wire logic CMD_WRITE_IN,
	input wire logic [7:0] CMD_CODE_IN,
	input wire logic [7:0] CMD_WDATA_IN,
	input wire logic CLEAR_FAULTS_IN,
	input wire logic OTHER_SHUTDOWN_IN,
	input wire logic OUTPUT_ON_CTRL_IN,
	input wire logic UC_FAULT_IN,
	output logic [7:0] CMD_RDATA_OUT,
	output logic CMD_ACK_OUT,
	output logic CMD_NACK_OUT,
	output logic HOST_ALERT_LINE_OUT,
	output logic HOST_ALERT_LINE_OE_OUT,
	output logic UC_STATUS_OUT,
	output logic OUTPUT_ENABLE_OUT
);
	logic [7:0] policy_reg;
	logic [1:0] fault_sync_reg;
	logic [1:0] ctrl_sync_reg;
	logic fault_seen_reg;
	logic [2:0] attempts_reg;
	uc_fault_pkg::seq_state_t state_reg;
	uc_fault_pkg::seq_state_t state_next;
	logic fault;
	logic ctrl_on;
	logic fault_rise;
	logic stop;
	logic [1:0] resp;
	logic [2:0] retry;
	logic more_tries;
	unit_timer_if tmr_if ();

	assign fault = fault_sync_reg[1];
	assign ctrl_on = ctrl_sync_reg[1];
	assign fault_rise = fault && !fault_seen_reg;
	assign stop = !ctrl_on || OTHER_SHUTDOWN_IN;
	assign resp = policy_reg[uc_fault_pkg::RESP_HI:uc_fault_pkg::RESP_LO];
	assign retry = policy_reg[uc_fault_pkg::RETRY_HI:uc_fault_pkg::RETRY_LO];
	// retry code 111 never runs out of attempts
	assign more_tries = (retry == uc_fault_pkg::RETRY_FOREVER) ||
		(attempts_reg < retry);

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	// fault sense and control pin are asynchronous to this clock
	always_ff @(posedge CLK_IN) begin
		if (SRST_IN) begin
			fault_sync_reg <= 2'h0;
			ctrl_sync_reg <= 2'h0;
			fault_seen_reg <= 1'b0;
		end else begin
			fault_sync_reg <= {fault_sync_reg[0], UC_FAULT_IN};
			ctrl_sync_reg <= {ctrl_sync_reg[0], OUTPUT_ON_CTRL_IN};
			fault_seen_reg <= fault;
		end
	end

	// ----------------------------------------------------------------
	// command register
	// ----------------------------------------------------------------
	// answers one cycle after the request; unknown codes are refused
	always_ff @(posedge CLK_IN) begin
		if (SRST_IN) begin
			policy_reg <= uc_fault_pkg::UC_POLICY_RESET;
			CMD_RDATA_OUT <= 8'h00;
			CMD_ACK_OUT <= 1'b0;
			CMD_NACK_OUT <= 1'b0;
		end else begin
			CMD_ACK_OUT <= CMD_VALID_IN && (CMD_CODE_IN == uc_fault_pkg::UC_POLICY_CODE);
			CMD_NACK_OUT <= CMD_VALID_IN && (CMD_CODE_IN != uc_fault_pkg::UC_POLICY_CODE);
			if (CMD_VALID_IN && CMD_CODE_IN == uc_fault_pkg::UC_POLICY_CODE) begin
				if (CMD_WRITE_IN) begin
					policy_reg <= CMD_WDATA_IN;
				end else begin
					CMD_RDATA_OUT <= policy_reg;
				end
			end else if (CMD_VALID_IN && !CMD_WRITE_IN) begin
				CMD_RDATA_OUT <= 8'h00;
			end
		end
	end

	// ----------------------------------------------------------------
	// alert and status reporting
	// ----------------------------------------------------------------
	// a new fault edge beats a clear in the same cycle so no event is lost
	always_ff @(posedge CLK_IN) begin
		if (SRST_IN) begin
			UC_STATUS_OUT <= 1'b0;
			HOST_ALERT_LINE_OE_OUT <= 1'b0;
			HOST_ALERT_LINE_OUT <= 1'b0;
		end else begin
			HOST_ALERT_LINE_OUT <= 1'b0; // open drain: only ever pulls low
			if (fault_rise) begin
				UC_STATUS_OUT <= 1'b1;
				HOST_ALERT_LINE_OE_OUT <= 1'b1;
			end else if (CLEAR_FAULTS_IN) begin
				UC_STATUS_OUT <= 1'b0;
				HOST_ALERT_LINE_OE_OUT <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// interval timer
	// ----------------------------------------------------------------
	unit_timer #(
		.DELAY_CYCLES(DELAY_UNIT_CYCLES),
		.RETRY_CYCLES(RETRY_UNIT_CYCLES)
	) timer_u (
		.clk_in(CLK_IN),
		.srst_in(SRST_IN),
		.tmr(tmr_if.timer)
	);

	// ----------------------------------------------------------------
	// response sequencer
	// ----------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		tmr_if.start = 1'b0;
		tmr_if.cancel = 1'b0;
		tmr_if.use_retry = 1'b1;
		tmr_if.units = policy_reg[uc_fault_pkg::UNITS_HI:uc_fault_pkg::UNITS_LO];
		if (stop) begin
			state_next = uc_fault_pkg::ST_OFF;
			tmr_if.cancel = 1'b1;
		end else begin
			unique case (state_reg)
				uc_fault_pkg::ST_OFF: begin
					state_next = uc_fault_pkg::ST_RUN;
				end
				uc_fault_pkg::ST_RUN: begin
					if (fault) begin
						unique case (resp)
							uc_fault_pkg::RESP_IGNORE: state_next = uc_fault_pkg::ST_RUN;
							uc_fault_pkg::RESP_DELAY: begin
								state_next = uc_fault_pkg::ST_DELAY;
								tmr_if.start = 1'b1;
								tmr_if.use_retry = 1'b0;
							end
							uc_fault_pkg::RESP_DISABLE_RETRY: begin
								if (retry == uc_fault_pkg::RETRY_NONE) begin
									state_next = uc_fault_pkg::ST_LATCHED;
								end else begin
									state_next = uc_fault_pkg::ST_OFF_WAIT;
									tmr_if.start = 1'b1;
								end
							end
							uc_fault_pkg::RESP_HOLD_OFF: state_next = uc_fault_pkg::ST_HOLD_OFF;
						endcase
					end
				end
				uc_fault_pkg::ST_DELAY: begin
					if (!fault) begin
						state_next = uc_fault_pkg::ST_RUN;
						tmr_if.cancel = 1'b1;
					end else if (tmr_if.done) begin
						if (retry == uc_fault_pkg::RETRY_NONE) begin
							state_next = uc_fault_pkg::ST_LATCHED;
						end else begin
							state_next = uc_fault_pkg::ST_OFF_WAIT;
							tmr_if.start = 1'b1;
						end
					end
				end
				uc_fault_pkg::ST_OFF_WAIT: begin
					if (tmr_if.done) begin
						if (more_tries) begin
							state_next = uc_fault_pkg::ST_RESTART;
							tmr_if.start = 1'b1;
						end else begin
							state_next = uc_fault_pkg::ST_LATCHED;
						end
					end
				end
				uc_fault_pkg::ST_RESTART: begin
					// timer keeps running so spacing is start to start; a failure on the
					// interval's last clock reloads it, or off-wait would wait forever
					if (fault) begin
						state_next = uc_fault_pkg::ST_OFF_WAIT;
						tmr_if.start = tmr_if.done;
					end else if (tmr_if.done) begin
						state_next = uc_fault_pkg::ST_RUN;
					end
				end
				uc_fault_pkg::ST_LATCHED: begin
					if (CLEAR_FAULTS_IN) begin
						state_next = uc_fault_pkg::ST_RUN;
					end
				end
				uc_fault_pkg::ST_HOLD_OFF: begin
					if (!fault) begin
						state_next = uc_fault_pkg::ST_RUN;
					end
				end
				default: state_next = uc_fault_pkg::ST_OFF;
			endcase
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (SRST_IN) begin
			state_reg <= uc_fault_pkg::ST_OFF;
		end else begin
			state_reg <= state_next;
		end
	end

	// ----------------------------------------------------------------
	// attempt counter and output enable
	// ----------------------------------------------------------------
	// counter restarts whenever the sequence is left through run or off
	always_ff @(posedge CLK_IN) begin
		if (SRST_IN) begin
			attempts_reg <= 3'h0;
			OUTPUT_ENABLE_OUT <= 1'b0;
		end else begin
			if (state_next == uc_fault_pkg::ST_RUN || state_next == uc_fault_pkg::ST_OFF) begin
				attempts_reg <= 3'h0;
			end else if (state_reg == uc_fault_pkg::ST_OFF_WAIT &&
					state_next == uc_fault_pkg::ST_RESTART && attempts_reg != 3'h7) begin
				attempts_reg <= attempts_reg + 3'h1;
			end
			OUTPUT_ENABLE_OUT <= (state_next == uc_fault_pkg::ST_RUN) ||
				(state_next == uc_fault_pkg::ST_DELAY) ||
				(state_next == uc_fault_pkg::ST_RESTART);
		end
	end
endmodule

// ==== verification/uc_fault_response_chk.sv ====
`timescale 1ns/1ns
module uc_fault_response_chk (
	input wire logic CLK_IN,
	input wire logic SRST_IN,
	input wire logic CMD_VALID_IN,
	input wire logic CMD_WRITE_IN,
	input wire logic [7:0] CMD_CODE_IN,
	input wire logic CLEAR_FAULTS_IN,
	input wire logic OUTPUT_ON_CTRL_IN,
	input wire logic UC_FAULT_IN,
	input wire logic [7:0] CMD_RDATA_OUT,
	input wire logic CMD_ACK_OUT,
	input wire logic CMD_NACK_OUT,
	input wire logic HOST_ALERT_LINE_OUT,
	input wire logic HOST_ALERT_LINE_OE_OUT,
	input wire logic UC_STATUS_OUT,
	input wire logic OUTPUT_ENABLE_OUT
);
	// ----------------------------------------------------------------
	// port relations
	// ----------------------------------------------------------------
	default clocking cb @(posedge CLK_IN);
	endclocking
	default disable iff (SRST_IN);
	ack_mapped_a: assert property (
		CMD_VALID_IN && CMD_CODE_IN == 8'hE6 |=> CMD_ACK_OUT && !CMD_NACK_OUT)
		else $error("mapped command not acknowledged");
	nack_unmapped_a: assert property (
		CMD_VALID_IN && CMD_CODE_IN != 8'hE6 |=> CMD_NACK_OUT && !CMD_ACK_OUT)
		else $error("unmapped command not refused");
	no_answer_a: assert property (
		!CMD_VALID_IN |=> !CMD_ACK_OUT && !CMD_NACK_OUT)
		else $error("answer without a request");
	unmapped_zero_a: assert property (
		CMD_VALID_IN && !CMD_WRITE_IN && CMD_CODE_IN != 8'hE6 |=> CMD_RDATA_OUT == 8'h00)
		else $error("unmapped read returned data");
	// alert is open drain: data stays low, enable follows the status bit
	alert_tracks_a: assert property (
		!HOST_ALERT_LINE_OUT && HOST_ALERT_LINE_OE_OUT == UC_STATUS_OUT)
		else $error("alert line and status disagree");
	fault_reports_a: assert property (
		$rose(UC_FAULT_IN) |-> ##[1:4] UC_STATUS_OUT && HOST_ALERT_LINE_OE_OUT)
		else $error("fault not reported in time");
	status_sticky_a: assert property (
		$fell(UC_STATUS_OUT) |-> $past(CLEAR_FAULTS_IN) || $past(SRST_IN))
		else $error("status dropped without clear");
	// sync stages give a few cycles of slack before the output must be off
	ctrl_off_a: assert property (
		!OUTPUT_ON_CTRL_IN [*6] |=> !OUTPUT_ENABLE_OUT)
		else $error("output on while commanded off");
endmodule

bind uc_fault_response uc_fault_response_chk chk (
	.CLK_IN(CLK_IN),
	.SRST_IN(SRST_IN),
	.CMD_VALID_IN(CMD_VALID_IN),
	.CMD_WRITE_IN(CMD_WRITE_IN),
	.CMD_CODE_IN(CMD_CODE_IN),
	.CLEAR_FAULTS_IN(CLEAR_FAULTS_IN),
	.OUTPUT_ON_CTRL_IN(OUTPUT_ON_CTRL_IN),
	.UC_FAULT_IN(UC_FAULT_IN),
	.CMD_RDATA_OUT(CMD_RDATA_OUT),
	.CMD_ACK_OUT(CMD_ACK_OUT),
	.CMD_NACK_OUT(CMD_NACK_OUT),
	.HOST_ALERT_LINE_OUT(HOST_ALERT_LINE_OUT),
	.HOST_ALERT_LINE_OE_OUT(HOST_ALERT_LINE_OE_OUT),
	.UC_STATUS_OUT(UC_STATUS_OUT),
	.OUTPUT_ENABLE_OUT(OUTPUT_ENABLE_OUT)
);

// ==== verification/host_model.sv ====
`timescale 1ns/1ns
module host_model (
	input wire logic clk_in,
	output logic valid_out,
	output logic write_out,
	output logic [7:0] code_out,
	output logic [7:0] wdata_out,
	input wire logic [7:0] rdata_in,
	input wire logic ack_in,
	input wire logic nack_in
);
	// ----------------------------------------------------------------
	// byte transfers
	// ----------------------------------------------------------------
	initial begin
		valid_out = 1'b0;
		write_out = 1'b0;
		code_out = 8'h00;
		wdata_out = 8'h00;
	end
	// request stands one cycle; idle bus shows inverted leftovers so stale
	// values never pass for a real request
	task automatic xfer(input logic w, input logic [7:0] c, input logic [7:0] d,
		output logic a, output logic n, output logic [7:0] r);
		@(negedge clk_in);
		valid_out = 1'b1;
		write_out = w;
		code_out = c;
		wdata_out = d;
		@(negedge clk_in);
		a = ack_in;
		n = nack_in;
		r = rdata_in;
		valid_out = 1'b0;
		write_out = ~w;
		code_out = ~c;
		wdata_out = ~d;
	endtask
endmodule

// ==== verification/uc_fault_response_bench.sv ====
`timescale 1ns/1ns
module uc_fault_response_bench;
	localparam logic [7:0] PC = uc_fault_pkg::UC_POLICY_CODE;
	logic clk_in, srst_in, valid, write, clr, other, ctrl, fault, ack, nack, ad, aoe, sts, en;
	logic [7:0] code, wdata, rdata, r;
	logic a, n;
	logic prev_en = 1'b0;
	int n_errors = 0;
	int total_checks = 0;
	int cyc = 0;
	int rises = 0;
	int gap = 0;
	int last_rise = 0;
	// ----------------------------------------------------------------
	// clock, instances, watchdog
	// ----------------------------------------------------------------
	initial begin
		clk_in = 1'b0;
		forever #10 clk_in = ~clk_in;
	end
	// short units keep retry runs to a few dozen cycles
	uc_fault_response #(.DELAY_UNIT_CYCLES(10), .RETRY_UNIT_CYCLES(8)) dut (
		.CLK_IN(clk_in), .SRST_IN(srst_in), .CMD_VALID_IN(valid), .CMD_WRITE_IN(write),
		.CMD_CODE_IN(code), .CMD_WDATA_IN(wdata), .CLEAR_FAULTS_IN(clr),
		.OTHER_SHUTDOWN_IN(other), .OUTPUT_ON_CTRL_IN(ctrl), .UC_FAULT_IN(fault),
		.CMD_RDATA_OUT(rdata), .CMD_ACK_OUT(ack), .CMD_NACK_OUT(nack),
		.HOST_ALERT_LINE_OUT(ad), .HOST_ALERT_LINE_OE_OUT(aoe), .UC_STATUS_OUT(sts),
		.OUTPUT_ENABLE_OUT(en));
	host_model host (.clk_in(clk_in), .valid_out(valid), .write_out(write),
		.code_out(code), .wdata_out(wdata), .rdata_in(rdata), .ack_in(ack), .nack_in(nack));
	// count output restarts and the spacing between the last two
	always @(posedge clk_in) begin
		cyc++;
		if (en === 1'b1 && prev_en !== 1'b1) begin
			rises++;
			gap = cyc - last_rise;
			last_rise = cyc;
		end
		prev_en = en;
		if (cyc > 5000) begin
			n_errors++;
			summarize();
		end
	end
	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic idle(input int k);
		repeat (k) @(negedge clk_in);
	endtask
	// bits: alert data, status, alert enable, output enable
	task automatic st(input logic [7:0] e);
		chk({4'h0, ad, sts, aoe, en}, e);
	endtask
	task automatic cmd(input logic w, input logic [7:0] c, input logic [7:0] d,
		input logic [7:0] er);
		host.xfer(w, c, d, a, n, r);
		chk({6'h00, a, n}, (c == PC) ? 8'h02 : 8'h01);
		if (!w) chk(r, er);
	endtask
	// hold a fault t cycles, drop it, then clear; restart counts checked on the way
	task automatic flt(input logic [7:0] p, input int t, input logic [7:0] e1,
		input logic [7:0] e2, input int er, input int eg);
		cmd(1'b1, PC, p, 8'h00);
		rises = 0;
		fault = 1'b1;
		idle(t);
		st(e1);
		chk(8'(rises), 8'(er));
		if (eg != 0) chk(8'(gap), 8'(eg));
		fault = 1'b0;
		idle(30);
		st(e2);
		clr = 1'b1;
		idle(1);
		clr = 1'b0;
		idle(12);
		st(8'h01);
	endtask
	task automatic summarize();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// ----------------------------------------------------------------
	// sequence
	// ----------------------------------------------------------------
	initial begin
		srst_in = 1'b1;
		clr = 1'b0;
		other = 1'b0;
		ctrl = 1'b0;
		fault = 1'b0;
		idle(20);
		srst_in = 1'b0;
		cmd(1'b0, PC, 8'h00, 8'h00);
		cmd(1'b0, 8'hE5, 8'h00, 8'h00);
		cmd(1'b1, 8'hE7, 8'h5A, 8'h00);
		cmd(1'b1, PC, 8'hA5, 8'h00);
		cmd(1'b0, PC, 8'h00, 8'hA5);
		ctrl = 1'b1;
		idle(12);
		st(8'h01);
		flt(8'h00, 12, 8'h07, 8'h07, 0, 0);
		flt(8'hC0, 12, 8'h06, 8'h07, 0, 0);
		flt(8'h81, 12, 8'h06, 8'h06, 0, 0);
		flt(8'h42, 18, 8'h07, 8'h07, 0, 0);
		flt(8'h42, 30, 8'h06, 8'h06, 0, 0);
		// endless retry, stopped by another fault, then by control
		cmd(1'b1, PC, 8'hB9, 8'h00);
		fault = 1'b1;
		idle(100);
		chk(8'(rises > 7), 8'h01);
		other = 1'b1;
		idle(4);
		rises = 0;
		idle(50);
		chk(8'(rises), 8'h00);
		// control goes off first so releasing the other fault cannot restart
		ctrl = 1'b0;
		idle(4);
		other = 1'b0;
		fault = 1'b0;
		idle(10);
		st(8'h06);
		clr = 1'b1;
		idle(1);
		clr = 1'b0;
		ctrl = 1'b1;
		idle(12);
		st(8'h01);
		flt(8'h91, 100, 8'h06, 8'h06, 2, 8);
		summarize();
	end
endmodule
